// >>> hw/rfa_defines.vh
// constants for the register file and data addressing core
`ifndef RFA_DEFINES_VH
`define RFA_DEFINES_VH

// register file
`define RFA_NREG        32
`define RFA_HI_BANK     1'b1
`define RFA_X_LO        5'h1a
`define RFA_Y_LO        5'h1c
`define RFA_Z_LO        5'h1e

// data space map
`define RFA_IO_BASE     16'h0020
`define RFA_SRAM_BASE   16'h0060
`define RFA_SRAM_END    16'h00e0
`define RFA_SRAM_AW     7
`define RFA_IO_SP       6'h3d

// region codes
`define RFA_RG_REG      2'h0
`define RFA_RG_IO       2'h1
`define RFA_RG_SRAM     2'h2
`define RFA_RG_NONE     2'h3

// addressing modes
`define RFA_M_DIRECT    3'h0
`define RFA_M_IO        3'h1
`define RFA_M_DISP      3'h2
`define RFA_M_IND       3'h3
`define RFA_M_PREDEC    3'h4
`define RFA_M_POSTINC   3'h5

// pointer selects
`define RFA_P_X         2'h0
`define RFA_P_Y         2'h1

// program side
`define RFA_PC_W        11
`define RFA_PC_MASK_SM  11'h3ff
`define RFA_PC_MASK_LG  11'h7ff
`define RFA_NOP         16'h0000

// interrupts
`define RFA_NIRQ        8
`define RFA_VEC_W       3

// reset values
`define RFA_SP_RST      8'h00
`define RFA_GPR_RST     8'h00

`endif

// >>> hw/rfa_sram.v
// 128 x 8 internal data memory with registered read data
`timescale 1ns/1ns
`include "rfa_defines.vh"

module rfa_sram (
	// clock
	input  wire                      clk_i,
	// access
	input  wire                      we_i,
	input  wire [`RFA_SRAM_AW-1:0]   addr_i,
	input  wire [7:0]                wdata_i,
	output reg  [7:0]                rdata_q
);

	reg [7:0] mem_q [0:(1<<`RFA_SRAM_AW)-1];

	// no reset on the array; contents are undefined after power-up
	always @(posedge clk_i) begin
		if (we_i) begin
			mem_q[addr_i] <= wdata_i;
		end
		rdata_q <= mem_q[addr_i];
	end

endmodule // rfa_sram

// >>> hw/rfa_core.v
// working register file, data-space decode, fetch and stack push
`timescale 1ns/1ns
`include "rfa_defines.vh"

module rfa_core #(
	parameter LARGE_VARIANT = 1
) (
	// clock and reset
	input  wire                     clk_i,
	input  wire                     sys_rst_i,
	// program fetch
	output wire [`RFA_PC_W-1:0]     prog_addr_o,
	input  wire [15:0]              prog_data_i,
	output wire [15:0]              instr_o,
	input  wire                     pc_load_i,
	input  wire [`RFA_PC_W-1:0]     pc_target_i,
	input  wire                     call_i,
	// register operands
	input  wire [4:0]               rd_sel_i,
	input  wire [4:0]               rr_sel_i,
	input  wire                     imm_form_i,
	input  wire                     alu_we_i,
	input  wire [7:0]               alu_res_i,
	output wire [7:0]               rd_data_o,
	output wire [7:0]               rr_data_o,
	// data access request
	input  wire                     mem_req_i,
	input  wire                     mem_we_i,
	input  wire [2:0]               mem_mode_i,
	input  wire [1:0]               ptr_sel_i,
	input  wire [5:0]               disp_i,
	input  wire [15:0]              direct_addr_i,
	input  wire [5:0]               io_addr_i,
	input  wire [4:0]               mem_reg_i,
	output wire                     busy_o,
	output wire                     mem_done_o,
	// peripheral i/o port
	output wire [5:0]               io_addr_o,
	output wire [7:0]               io_wdata_o,
	output wire                     io_we_o,
	output wire                     io_re_o,
	input  wire [7:0]               io_rdata_i,
	// interrupts
	input  wire                     int_en_i,
	input  wire [`RFA_NIRQ-1:0]     irq_i,
	output wire                     int_ack_o,
	output wire [`RFA_VEC_W-1:0]    int_vec_o,
	// status
	output wire [7:0]               stack_top_o
);

	localparam [1:0] S_IDLE = 2'h0;
	localparam [1:0] S_ACC1 = 2'h1;
	localparam [1:0] S_ACC2 = 2'h2;

	localparam [1:0] P_NONE = 2'h0;
	localparam [1:0] P_LO   = 2'h1;
	localparam [1:0] P_HI   = 2'h2;

	reg  [1:0]             state_q;
	reg  [1:0]             state_d;
	reg  [1:0]             push_q;
	reg  [`RFA_PC_W-1:0]   pc_q;
	reg  [`RFA_PC_W-1:0]   jump_q;
	reg  [15:0]            instr_q;
	reg  [7:0]             rd_data_q;
	reg  [7:0]             rr_data_q;
	reg  [4:0]             alu_dst_q;
	reg  [15:0]            addr_q;
	reg                    we_q;
	reg  [7:0]             wdata_q;
	reg  [4:0]             mreg_q;
	reg                    busy_q;
	reg                    done_q;
	reg  [5:0]             io_addr_q;
	reg  [7:0]             io_wdata_q;
	reg                    io_we_q;
	reg                    io_re_q;
	reg  [7:0]             io_rd_q;
	reg  [7:0]             ld_reg_q;
	reg                    ack_q;
	reg  [`RFA_VEC_W-1:0]  vec_q;
	reg  [7:0]             sp_q;

	wire [8*`RFA_NREG-1:0] gpr_flat;
	wire [7:0]             sram_rdata;

	// register file read helpers; pairs are even low, odd high
	reg  [4:0]             ptr_lo_idx;
	wire [4:0]             ptr_hi_idx;
	wire [15:0]            ptr_val;

	always @* begin
		case (ptr_sel_i)
			`RFA_P_X: ptr_lo_idx = `RFA_X_LO;
			`RFA_P_Y: ptr_lo_idx = `RFA_Y_LO;
			default:  ptr_lo_idx = `RFA_Z_LO;
		endcase
	end

	assign ptr_hi_idx = {ptr_lo_idx[4:1], 1'b1};
	assign ptr_val    = {gpr_flat[{ptr_hi_idx, 3'h0} +: 8],
	                     gpr_flat[{ptr_lo_idx, 3'h0} +: 8]};

	// data-space region of an address
	function [1:0] region;
		input [15:0] a;
		begin
			if (a < `RFA_IO_BASE)
				region = `RFA_RG_REG;
			else if (a < `RFA_SRAM_BASE)
				region = `RFA_RG_IO;
			else if (a < `RFA_SRAM_END)
				region = `RFA_RG_SRAM;
			else
				region = `RFA_RG_NONE;
		end
	endfunction

	// launch decode: what the next access targets
	reg                    take_mem;
	reg                    take_call;
	reg                    take_irq;
	reg                    launch_go;
	reg                    launch_we;
	reg  [15:0]            launch_addr;
	reg  [7:0]             launch_wdata;
	reg                    ptr_we;
	reg  [15:0]            ptr_new;
	reg  [`RFA_VEC_W-1:0]  irq_vec;
	integer                k;

	// lowest index is the lowest vector address and wins
	always @* begin
		irq_vec = {`RFA_VEC_W{1'b0}};
		for (k = `RFA_NIRQ - 1; k >= 0; k = k - 1) begin
			if (irq_i[k]) begin
				irq_vec = k[`RFA_VEC_W-1:0];
			end
		end
	end

	always @* begin
		take_mem     = (state_q == S_IDLE) && mem_req_i;
		take_call    = (state_q == S_IDLE) && !mem_req_i && call_i;
		take_irq     = (state_q == S_IDLE) && !mem_req_i && !call_i &&
		               int_en_i && (|irq_i);
		launch_go    = 1'b0;
		launch_we    = 1'b0;
		launch_addr  = 16'h0000;
		launch_wdata = 8'h00;
		ptr_we       = 1'b0;
		ptr_new      = ptr_val;
		if (take_mem) begin
			launch_go    = 1'b1;
			launch_we    = mem_we_i;
			launch_wdata = gpr_flat[{mem_reg_i, 3'h0} +: 8];
			case (mem_mode_i)
				`RFA_M_DIRECT: launch_addr = direct_addr_i;
				`RFA_M_IO:     launch_addr = {10'h000, io_addr_i} +
				                             `RFA_IO_BASE;
				`RFA_M_DISP:   launch_addr = ptr_val + {10'h000, disp_i};
				`RFA_M_PREDEC: begin
					launch_addr = ptr_val - 16'h0001;
					ptr_we      = 1'b1;
					ptr_new     = ptr_val - 16'h0001;
				end
				`RFA_M_POSTINC: begin
					launch_addr = ptr_val;
					ptr_we      = 1'b1;
					ptr_new     = ptr_val + 16'h0001;
				end
				default:       launch_addr = ptr_val;
			endcase
		end else if (take_call || take_irq) begin
			// low byte first; stack grows downward from the loaded pointer
			launch_go    = 1'b1;
			launch_we    = 1'b1;
			launch_addr  = {8'h00, sp_q};
			launch_wdata = pc_q[7:0];
		end else if ((state_q == S_ACC2) && (push_q == P_LO)) begin
			launch_go    = 1'b1;
			launch_we    = 1'b1;
			launch_addr  = {8'h00, sp_q};
			launch_wdata = {5'h00, pc_q[`RFA_PC_W-1:8]};
		end
	end

	wire [15:0] launch_io = launch_addr - `RFA_IO_BASE;
	wire [1:0]  launch_rg = region(launch_addr);
	wire        launch_sp = (launch_rg == `RFA_RG_IO) && (launch_io[5:0] == `RFA_IO_SP);
	wire [15:0] acc_io    = addr_q - `RFA_IO_BASE;
	wire [15:0] acc_sram  = addr_q - `RFA_SRAM_BASE;
	wire [1:0]  acc_rg    = region(addr_q);
	wire        acc_sp    = (acc_rg == `RFA_RG_IO) && (acc_io[5:0] == `RFA_IO_SP);
	wire        acc1      = (state_q == S_ACC1);
	wire        acc2      = (state_q == S_ACC2);
	wire        sram_we   = acc1 && we_q && (acc_rg == `RFA_RG_SRAM);

	// load data picked by the region of the finished access
	reg  [7:0] load_data;

	always @* begin
		case (acc_rg)
			`RFA_RG_REG:  load_data = ld_reg_q;
			`RFA_RG_IO:   load_data = acc_sp ? sp_q : io_rd_q;
			`RFA_RG_SRAM: load_data = sram_rdata;
			default:      load_data = 8'h00;
		endcase
	end

	// single general write port; memory side owns it while busy
	reg        wa_en;
	reg  [4:0] wa_idx;
	reg  [7:0] wa_data;

	always @* begin
		wa_en   = 1'b0;
		wa_idx  = alu_dst_q;
		wa_data = alu_res_i;
		if (acc1 && we_q && (acc_rg == `RFA_RG_REG) && (push_q == P_NONE)) begin
			wa_en   = 1'b1;
			wa_idx  = addr_q[4:0];
			wa_data = wdata_q;
		end else if (acc2 && !we_q && (push_q == P_NONE)) begin
			wa_en   = 1'b1;
			wa_idx  = mreg_q;
			wa_data = load_data;
		end else if (alu_we_i && (state_q == S_IDLE)) begin
			wa_en   = 1'b1;
		end
	end

	genvar g;
	generate
		for (g = 0; g < `RFA_NREG; g = g + 1) begin : g_gpr
			localparam [4:0] IDX = g;
			reg [7:0] q;
			always @(posedge clk_i or posedge sys_rst_i) begin
				if (sys_rst_i) begin
					q <= `RFA_GPR_RST;
				end else if (wa_en && (wa_idx == IDX)) begin
					q <= wa_data;
				end else if (ptr_we && (ptr_lo_idx == IDX)) begin
					q <= ptr_new[7:0];
				end else if (ptr_we && (ptr_hi_idx == IDX)) begin
					q <= ptr_new[15:8];
				end
			end
			assign gpr_flat[8*g +: 8] = q;
		end
	endgenerate

	// operand read; immediate forms map onto the upper half
	wire [4:0] rd_idx = imm_form_i ? {`RFA_HI_BANK, rd_sel_i[3:0]} : rd_sel_i;

	always @(posedge clk_i or posedge sys_rst_i) begin
		if (sys_rst_i) begin
			rd_data_q <= 8'h00;
			rr_data_q <= 8'h00;
			alu_dst_q <= 5'h00;
		end else begin
			// bypass so a back-to-back dependent operation sees the fresh value
			rd_data_q <= (wa_en && (wa_idx == rd_idx)) ? wa_data :
			             gpr_flat[{rd_idx, 3'h0} +: 8];
			rr_data_q <= (wa_en && (wa_idx == rr_sel_i)) ? wa_data :
			             gpr_flat[{rr_sel_i, 3'h0} +: 8];
			alu_dst_q <= rd_idx;
		end
	end

	// access sequencer
	always @* begin
		state_d = state_q;
		case (state_q)
			S_IDLE:  state_d = launch_go ? S_ACC1 : S_IDLE;
			S_ACC1:  state_d = S_ACC2;
			S_ACC2:  state_d = launch_go ? S_ACC1 : S_IDLE;
			default: state_d = S_IDLE;
		endcase
	end

	wire [`RFA_PC_W-1:0] pc_mask = LARGE_VARIANT ? `RFA_PC_MASK_LG : `RFA_PC_MASK_SM;

	always @(posedge clk_i or posedge sys_rst_i) begin
		if (sys_rst_i) begin
			state_q    <= S_IDLE;
			push_q     <= P_NONE;
			pc_q       <= {`RFA_PC_W{1'b0}};
			jump_q     <= {`RFA_PC_W{1'b0}};
			instr_q    <= `RFA_NOP;
			addr_q     <= 16'h0000;
			we_q       <= 1'b0;
			wdata_q    <= 8'h00;
			mreg_q     <= 5'h00;
			busy_q     <= 1'b0;
			done_q     <= 1'b0;
			io_addr_q  <= 6'h00;
			io_wdata_q <= 8'h00;
			io_we_q    <= 1'b0;
			io_re_q    <= 1'b0;
			io_rd_q    <= 8'h00;
			ld_reg_q   <= 8'h00;
			ack_q      <= 1'b0;
			vec_q      <= {`RFA_VEC_W{1'b0}};
			sp_q       <= `RFA_SP_RST;
		end else begin
			state_q <= state_d;
			busy_q  <= (state_d != S_IDLE);
			done_q  <= acc2 && (push_q == P_NONE);
			ack_q   <= take_irq;
			io_we_q <= launch_go && launch_we && (launch_rg == `RFA_RG_IO) && !launch_sp;
			io_re_q <= launch_go && !launch_we && (launch_rg == `RFA_RG_IO) && !launch_sp;
			if (launch_go) begin
				addr_q     <= launch_addr;
				we_q       <= launch_we;
				wdata_q    <= launch_wdata;
				io_addr_q  <= launch_io[5:0];
				io_wdata_q <= launch_wdata;
			end
			if (take_mem) begin
				mreg_q <= mem_reg_i;
			end
			if (take_call) begin
				jump_q <= pc_target_i & pc_mask;
				push_q <= P_LO;
			end
			if (take_irq) begin
				// one vector word per source at the bottom of program memory
				jump_q <= {{(`RFA_PC_W-`RFA_VEC_W){1'b0}}, irq_vec};
				vec_q  <= irq_vec;
				push_q <= P_LO;
			end
			if (launch_go && (take_call || take_irq || (push_q == P_LO))) begin
				sp_q <= sp_q - 8'h01;
			end else if (acc1 && we_q && acc_sp && (push_q == P_NONE)) begin
				sp_q <= wdata_q;
			end
			if (acc1) begin
				io_rd_q  <= io_rdata_i;
				ld_reg_q <= gpr_flat[{addr_q[4:0], 3'h0} +: 8];
			end
			if (acc2 && (push_q == P_LO)) begin
				push_q <= P_HI;
			end else if (acc2 && (push_q == P_HI)) begin
				push_q  <= P_NONE;
				pc_q    <= jump_q;
				instr_q <= `RFA_NOP;
			end
			// fetch runs only while nothing holds the pipe
			if ((state_q == S_IDLE) && !launch_go) begin
				if (pc_load_i) begin
					pc_q    <= pc_target_i & pc_mask;
					instr_q <= `RFA_NOP;
				end else begin
					pc_q    <= (pc_q + 1'b1) & pc_mask;
					instr_q <= prog_data_i;
				end
			end
		end
	end

	rfa_sram u_sram (
		.clk_i   (clk_i),
		.we_i    (sram_we),
		.addr_i  (acc_sram[`RFA_SRAM_AW-1:0]),
		.wdata_i (wdata_q),
		.rdata_q (sram_rdata)
	);

	assign prog_addr_o = pc_q;
	assign instr_o     = instr_q;
	assign rd_data_o   = rd_data_q;
	assign rr_data_o   = rr_data_q;
	assign busy_o      = busy_q;
	assign mem_done_o  = done_q;
	assign io_addr_o   = io_addr_q;
	assign io_wdata_o  = io_wdata_q;
	assign io_we_o     = io_we_q;
	assign io_re_o     = io_re_q;
	assign int_ack_o   = ack_q;
	assign int_vec_o   = vec_q;
	assign stack_top_o = sp_q;

endmodule // rfa_core

// >>> sim/rfa_core_chk.sv
// port timing assertions for the register file core
`timescale 1ns/1ns
module rfa_core_chk (
	// clock and reset
	input wire logic        clk_i,
	input wire logic        sys_rst_i,
	// requests
	input wire logic        mem_req_i,
	input wire logic        mem_we_i,
	input wire logic        call_i,
	input wire logic        pc_load_i,
	input wire logic        int_en_i,
	input wire logic [7:0]  irq_i,
	input wire logic [10:0] pc_target_i,
	input wire logic [15:0] prog_data_i,
	// answers
	input wire logic        busy_o,
	input wire logic        mem_done_o,
	input wire logic        io_we_o,
	input wire logic        io_re_o,
	input wire logic        int_ack_o,
	input wire logic [2:0]  int_vec_o,
	input wire logic [7:0]  stack_top_o,
	input wire logic [10:0] prog_addr_o,
	input wire logic [15:0] instr_o
);
	default clocking @(posedge clk_i); endclocking
	default disable iff (sys_rst_i);

	// bit 0 wins, so scan downwards and keep the last hit
	function automatic logic [2:0] first_irq(input logic [7:0] v);
		first_irq = 3'h0;
		for (int i = 7; i >= 0; i--)
			if (v[i]) first_irq = 3'(i);
	endfunction

	sequence mem_take_s; !busy_o && mem_req_i; endsequence
	sequence push_take_s; !busy_o && !mem_req_i && call_i; endsequence
	sequence irq_take_s; !busy_o && !mem_req_i && !call_i && int_en_i && |irq_i; endsequence
	sequence free_s; !busy_o && !mem_req_i && !call_i && !(int_en_i && |irq_i); endsequence
	sequence push_s; busy_o [*4] ##1 !busy_o; endsequence

	mem_timing_a: assert property (
		mem_take_s |=> busy_o [*2] ##1 (!busy_o && mem_done_o))
		else $error("data access took the wrong number of cycles");
	done_after_busy_a: assert property (
		mem_done_o |-> $past(busy_o) && !busy_o)
		else $error("done pulse without a busy access before it");
	io_store_a: assert property (
		io_we_o |-> $past(mem_req_i && mem_we_i && !busy_o))
		else $error("peripheral write strobe without a store request");
	io_load_a: assert property (
		io_re_o |-> $past(mem_req_i && !mem_we_i && !busy_o))
		else $error("peripheral read strobe without a load request");
	push_len_a: assert property (push_take_s |=> push_s)
		else $error("return push busy span wrong");
	push_sp_a: assert property (
		push_take_s |-> ##5 stack_top_o == $past(stack_top_o, 5) - 8'h02)
		else $error("stack top not lowered by two after a call");
	call_jump_a: assert property (
		push_take_s |-> ##5 prog_addr_o == $past(pc_target_i, 5))
		else $error("call did not reach its target");
	irq_pick_a: assert property (
		irq_take_s |=> int_ack_o && int_vec_o == first_irq($past(irq_i)))
		else $error("wrong interrupt chosen");
	irq_gate_a: assert property (!int_en_i |=> !int_ack_o)
		else $error("interrupt taken while globally disabled");
	fetch_step_a: assert property (
		free_s and !pc_load_i |=> prog_addr_o == $past(prog_addr_o) + 11'h001
		&& instr_o == $past(prog_data_i))
		else $error("fetch did not advance by one word");
	jump_load_a: assert property (
		free_s and pc_load_i |=> prog_addr_o == $past(pc_target_i) && instr_o == 16'h0000)
		else $error("jump target or flush wrong");
endmodule // rfa_core_chk

bind rfa_core rfa_core_chk u_chk (
	.clk_i(clk_i), .sys_rst_i(sys_rst_i), .mem_req_i(mem_req_i), .mem_we_i(mem_we_i),
	.call_i(call_i), .pc_load_i(pc_load_i), .int_en_i(int_en_i), .irq_i(irq_i),
	.pc_target_i(pc_target_i), .prog_data_i(prog_data_i), .busy_o(busy_o),
	.mem_done_o(mem_done_o), .io_we_o(io_we_o), .io_re_o(io_re_o), .int_ack_o(int_ack_o),
	.int_vec_o(int_vec_o), .stack_top_o(stack_top_o), .prog_addr_o(prog_addr_o),
	.instr_o(instr_o)
);

// >>> sim/rfa_partner.sv
// program memory and peripheral stand-in for the core
`timescale 1ns/1ns
module rfa_partner (
	// from the core
	input  wire logic [10:0] prog_addr_i,
	input  wire logic [5:0]  io_addr_i,
	input  wire logic        io_re_i,
	// to the core
	output logic [15:0]      prog_data_o,
	output logic [7:0]       io_rdata_o
);
	// word tied to its address so a skipped fetch shows
	assign prog_data_o = {5'h15, prog_addr_i};
	// idle bus shows a different pattern, never the read value
	assign io_rdata_o = io_re_i ? {2'h2, io_addr_i} : {2'h1, ~io_addr_i};
endmodule // rfa_partner

// >>> sim/cpu_register_file_data_addressing_test.sv
// self-checking bench for the register file core
`timescale 1ns/1ns
`include "rfa_defines.vh"
module cpu_register_file_data_addressing_test;
	typedef struct {
		logic [15:0] a;
		logic [7:0]  v;
		logic [7:0]  e;
	} rfa_row_t;
	logic        clk_i, sys_rst_i, pc_load_i, call_i, imm_form_i, alu_we_i;
	logic        mem_req_i, mem_we_i, int_en_i, busy_o, mem_done_o;
	logic        io_we_o, io_re_o, int_ack_o;
	logic [1:0]  ptr_sel_i;
	logic [2:0]  mem_mode_i, int_vec_o;
	logic [4:0]  rd_sel_i, rr_sel_i, mem_reg_i;
	logic [5:0]  disp_i, io_addr_i, io_addr_o, io_seen_a;
	logic [7:0]  alu_res_i, rd_data_o, rr_data_o, io_wdata_o, io_rdata_i;
	logic [7:0]  irq_i, stack_top_o, io_seen_d, x, y;
	logic [10:0] pc_target_i, prog_addr_o, pc_at_take;
	logic [15:0] prog_data_i, instr_o, direct_addr_i;
	int          n_mismatch, cmp_count, i, k;
	// stack row last: later call test relies on its value
	rfa_row_t    rows [6] = '{'{16'h0003, 8'h5a, 8'h5a}, '{16'h0060, 8'h11, 8'h11},
		'{16'h00df, 8'hee, 8'hee}, '{16'h00e0, 8'h77, 8'h00},
		'{16'h0025, 8'h33, 8'h85}, '{16'h005d, 8'hd0, 8'hd0}};

	rfa_core #(.LARGE_VARIANT(1)) uut (
		.clk_i(clk_i), .sys_rst_i(sys_rst_i), .prog_addr_o(prog_addr_o),
		.prog_data_i(prog_data_i), .instr_o(instr_o), .pc_load_i(pc_load_i),
		.pc_target_i(pc_target_i), .call_i(call_i), .rd_sel_i(rd_sel_i),
		.rr_sel_i(rr_sel_i), .imm_form_i(imm_form_i), .alu_we_i(alu_we_i),
		.alu_res_i(alu_res_i), .rd_data_o(rd_data_o), .rr_data_o(rr_data_o),
		.mem_req_i(mem_req_i), .mem_we_i(mem_we_i), .mem_mode_i(mem_mode_i),
		.ptr_sel_i(ptr_sel_i), .disp_i(disp_i), .direct_addr_i(direct_addr_i),
		.io_addr_i(io_addr_i), .mem_reg_i(mem_reg_i), .busy_o(busy_o),
		.mem_done_o(mem_done_o), .io_addr_o(io_addr_o), .io_wdata_o(io_wdata_o),
		.io_we_o(io_we_o), .io_re_o(io_re_o), .io_rdata_i(io_rdata_i),
		.int_en_i(int_en_i), .irq_i(irq_i), .int_ack_o(int_ack_o),
		.int_vec_o(int_vec_o), .stack_top_o(stack_top_o)
	);
	rfa_partner u_part (
		.prog_addr_i(prog_addr_o), .io_addr_i(io_addr_o), .io_re_i(io_re_o),
		.prog_data_o(prog_data_i), .io_rdata_o(io_rdata_i)
	);

	always @(posedge clk_i) begin
		if (io_we_o === 1'b1) begin
			io_seen_a <= io_addr_o;
			io_seen_d <= io_wdata_o;
		end
	end

	task chk(input logic [15:0] g, input logic [15:0] e);
		cmp_count++;
		if (g !== e) begin
			n_mismatch++;
			$display("unexpected at %0t: got %h want %h", $time, g, e);
		end
	endtask

	task end_sim;
		$display("comparisons %0d mismatches %0d", cmp_count, n_mismatch);
		if (n_mismatch == 0 && cmp_count > 0)
			$display("bench passed");
		else
			$display("bench failed");
		$finish;
	endtask

	task wreg(input logic [4:0] r, input logic [7:0] v, input logic imm = 1'b0);
		rd_sel_i <= r;
		imm_form_i <= imm;
		@(posedge clk_i);
		alu_res_i <= v;
		alu_we_i <= 1'b1;
		@(posedge clk_i);
		alu_we_i <= 1'b0;
		imm_form_i <= 1'b0;
	endtask

	task rreg(input logic [4:0] a, input logic [4:0] b, output logic [7:0] ra,
		output logic [7:0] rb);
		rd_sel_i <= a;
		rr_sel_i <= b;
		@(posedge clk_i);
		@(negedge clk_i);
		ra = rd_data_o;
		rb = rr_data_o;
		@(posedge clk_i);
	endtask

	// pointer modes carry the pointer in a[9:8] and the offset in a[5:0]
	task mem(input logic [2:0] m, input logic we, input logic [15:0] a, input logic [4:0] r);
		mem_mode_i <= m;
		mem_we_i <= we;
		direct_addr_i <= a;
		ptr_sel_i <= a[9:8];
		disp_i <= a[5:0];
		io_addr_i <= a[5:0];
		mem_reg_i <= r;
		mem_req_i <= 1'b1;
		@(posedge clk_i);
		mem_req_i <= 1'b0;
		for (k = 0; k < 6 && mem_done_o !== 1'b1; k++) @(negedge clk_i);
		chk(16'(k), 16'h0003);
		@(posedge clk_i);
	endtask

	initial begin
		clk_i = 1'b0;
		forever #10 clk_i = ~clk_i;
	end

	initial begin
		#200000;
		n_mismatch++;
		end_sim();
	end

	initial begin
		{sys_rst_i, pc_load_i, call_i, imm_form_i, alu_we_i} = 5'h10;
		{mem_req_i, mem_we_i, int_en_i, ptr_sel_i, mem_mode_i} = 8'h00;
		{rd_sel_i, rr_sel_i, mem_reg_i, disp_i, io_addr_i} = 27'h0;
		{alu_res_i, irq_i, pc_target_i, direct_addr_i} = 43'h0;
		repeat (4) @(posedge clk_i);
		@(negedge clk_i);
		chk(stack_top_o, 8'h00);
		chk(instr_o, `RFA_NOP);
		@(posedge clk_i);
		sys_rst_i <= 1'b0;
		$display("test reset done");
		for (i = 0; i < 6; i++) begin
			wreg(5'd1, rows[i].v);
			mem(`RFA_M_DIRECT, 1'b1, rows[i].a, 5'd1);
			mem(`RFA_M_DIRECT, 1'b0, rows[i].a, 5'd2);
			rreg(5'd2, 5'd1, x, y);
			chk(x, rows[i].e);
			chk(y, rows[i].v);
		end
		chk(io_seen_a, 6'h05);
		chk(io_seen_d, 8'h33);
		chk(stack_top_o, 8'hd0);
		$display("test data map done");
		wreg(5'd26, 8'hff);
		wreg(5'd27, 8'h00);
		mem(`RFA_M_POSTINC, 1'b0, 16'h0000, 5'd4);
		rreg(5'd26, 5'd27, x, y);
		chk({y, x}, 16'h0100);
		wreg(5'd26, 8'h60);
		wreg(5'd27, 8'h00);
		mem(`RFA_M_POSTINC, 1'b0, 16'h0000, 5'd4);
		rreg(5'd4, 5'd26, x, y);
		chk(x, 8'h11);
		chk(y, 8'h61);
		mem(`RFA_M_PREDEC, 1'b0, 16'h0000, 5'd5);
		rreg(5'd5, 5'd26, x, y);
		chk(x, 8'h11);
		chk(y, 8'h60);
		wreg(5'd28, 8'hdf);
		wreg(5'd29, 8'h00);
		mem(`RFA_M_IND, 1'b0, 16'h0100, 5'd6);
		rreg(5'd6, 5'd28, x, y);
		chk(x, 8'hee);
		chk(y, 8'hdf);
		wreg(5'd30, 8'ha0);
		wreg(5'd31, 8'h00);
		mem(`RFA_M_DISP, 1'b0, 16'h023f, 5'd7);
		rreg(5'd7, 5'd30, x, y);
		chk(x, 8'hee);
		chk(y, 8'ha0);
		$display("test pointers done");
		wreg(5'd3, 8'h9c, 1'b1);
		rreg(5'd19, 5'd3, x, y);
		chk(x, 8'h9c);
		chk(y, 8'h5a);
		mem(`RFA_M_IO, 1'b0, 16'h0007, 5'd8);
		mem(`RFA_M_IO, 1'b1, 16'h0009, 5'd8);
		chk(io_seen_a, 6'h09);
		chk(io_seen_d, 8'h87);
		$display("test operands done");
		pc_target_i <= 11'h7fe;
		pc_load_i <= 1'b1;
		@(posedge clk_i);
		pc_load_i <= 1'b0;
		@(negedge clk_i);
		chk(prog_addr_o, 11'h7fe);
		@(negedge clk_i);
		chk(instr_o, {5'h15, 11'h7fe});
		@(negedge clk_i);
		chk(prog_addr_o, 11'h000);
		@(posedge clk_i);
		pc_target_i <= 11'h123;
		call_i <= 1'b1;
		@(negedge clk_i);
		pc_at_take = prog_addr_o;
		@(posedge clk_i);
		call_i <= 1'b0;
		repeat (6) @(negedge clk_i);
		chk(stack_top_o, 8'hce);
		@(posedge clk_i);
		mem(`RFA_M_DIRECT, 1'b0, 16'h00d0, 5'd9);
		mem(`RFA_M_DIRECT, 1'b0, 16'h00cf, 5'd10);
		rreg(5'd9, 5'd10, x, y);
		chk(x, pc_at_take[7:0]);
		chk(y, {5'h0, pc_at_take[10:8]});
		$display("test fetch and call done");
		// held off first so the global gate is exercised
		irq_i <= 8'h60;
		repeat (3) @(posedge clk_i);
		int_en_i <= 1'b1;
		for (k = 0; k < 8 && int_ack_o !== 1'b1; k++) @(negedge clk_i);
		chk(int_vec_o, 3'h5);
		@(posedge clk_i);
		irq_i <= 8'h00;
		int_en_i <= 1'b0;
		repeat (4) @(negedge clk_i);
		chk(prog_addr_o, 11'h005);
		chk(stack_top_o, 8'hcc);
		$display("test interrupt done");
		@(posedge clk_i);
		sys_rst_i <= 1'b1;
		@(negedge clk_i);
		chk(stack_top_o, 8'h00);
		@(posedge clk_i);
		sys_rst_i <= 1'b0;
		$display("test second reset done");
		end_sim();
	end
endmodule // cpu_register_file_data_addressing_test
